// *** core/bbc_pkg.sv ***
// Constants, types and structs shared by the branch, bit and control decoder.
// Function
// - Short branch taken only on carry/no-carry/zero/nonzero; one byte, two cycles, flags kept.
// - Short branch displacement is 5-bit signed, reach -15 to +16.
// - Branch-if-bit-clear: three bytes, five cycles, branches when selected bit is zero.
// - Branch-if-bit-high: three bytes, five cycles, branches when selected bit is one.
// - Both bit tests copy the tested bit into carry; zero flag kept.
// - Bit test displacement is third byte, 8-bit signed, reach -126 to +129.
// - Bit set, clear and test reach any bit of any data byte.
// - Bit set forces selected bit to one; two bytes, four cycles, flags kept.
// - Bit clear forces selected bit to zero; two bytes, four cycles, flags kept.
// - No-op, return, interrupt return, halt and idle: one byte, two cycles each.
// - Only interrupt return changes zero and carry among control instructions.
// - With watchdog option selected, halt executes as idle instead.
// - Jump and call carry 12-bit absolute target; two bytes, four cycles, flags kept.
// - Bit test opcode holds bit number and polarity; byte two address, three displacement.
// - Bit set and clear opcode holds bit number; byte two is data address.
package bbc_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int         PC_W        = 12;
  localparam int         DATA_W      = 8;
  localparam int         DADDR_W     = 8;
  localparam logic [2:0] STACK_DEPTH = 3'd6;
  localparam logic [11:0] PC_RESET   = 12'h000;

  // ----------------------------------------------------------------------
  // Cycle counts and instruction lengths
  // ----------------------------------------------------------------------
  localparam logic [2:0]  CYC_SHORT = 3'd2;
  localparam logic [2:0]  CYC_BTEST = 3'd5;
  localparam logic [2:0]  CYC_BITOP = 3'd4;
  localparam logic [2:0]  CYC_JUMP  = 3'd4;
  localparam logic [2:0]  CYC_CTRL  = 3'd2;
  localparam logic [11:0] LEN_ONE   = 12'd1;
  localparam logic [11:0] LEN_TWO   = 12'd2;
  localparam logic [11:0] LEN_THREE = 12'd3;
  localparam logic [11:0] BT_BASE   = 12'd2;

  // ----------------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] LO_CALL  = 4'h1;
  localparam logic [3:0] LO_JUMP  = 4'h9;
  localparam logic [3:0] LO_BTEST = 4'h3;
  localparam logic [3:0] LO_BITOP = 4'hB;
  localparam logic [1:0] COND_NZ  = 2'b00;
  localparam logic [1:0] COND_NC  = 2'b01;
  localparam logic [1:0] COND_Z   = 2'b10;
  localparam logic [1:0] COND_C   = 2'b11;
  localparam logic [7:0] OP_NOP   = 8'h05;
  localparam logic [7:0] OP_RET   = 8'h25;
  localparam logic [7:0] OP_INTERRUPT_RETURN  = 8'h45;
  localparam logic [7:0] OP_HALT  = 8'h65;
  localparam logic [7:0] OP_IDLE  = 8'h85;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_EXEC  = 3'b010,
    ST_SLEEP = 3'b100
  } bbc_state_e;

  typedef struct packed {
    logic        rd;
    logic [11:0] addr;
  } bbc_preq_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bbc_dreq_s;

endpackage

// *** core/bbc_bitop.sv ***
// Selects one bit of a data byte and builds the byte with that bit forced.
module bbc_bitop (
  // Operand
  input  wire logic [7:0] byte_in,
  input  wire logic [2:0] bit_num,
  input  wire logic       set_val,
  // Results
  output      logic       bit_out,
  output      logic [7:0] byte_out
);

  assign bit_out = byte_in[bit_num];

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign byte_out[i] = (bit_num == 3'(i)) ? set_val : byte_in[i];
  end

endmodule

// *** core/bbc_core.sv ***
// Sequencer for branch, bit manipulation, control and jump instructions.
module bbc_core (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Program memory
  output      bbc_pkg::bbc_preq_s  prog_req,
  input  wire logic [7:0]          prog_data,
  // Data space memory
  output      bbc_pkg::bbc_dreq_s  data_req,
  input  wire logic [7:0]          data_rdata,
  // Option and wake pins
  input  wire logic                wdog_option,
  input  wire logic                wake,
  // Status
  output      logic [11:0]         instr_addr,
  output      logic                flag_z,
  output      logic                flag_c,
  output      logic                halted,
  output      logic                idle,
  output      logic                unsupported
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] wd_sync;
  logic [1:0] wk_sync;
  logic       wk_prev;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wd_sync <= 2'b00;
      wk_sync <= 2'b00;
      wk_prev <= 1'b0;
    end else begin
      wd_sync <= {wd_sync[0], wdog_option};
      wk_sync <= {wk_sync[0], wake};
      wk_prev <= wk_sync[1];
    end
  end

  wire wd_on     = wd_sync[1];
  wire wake_rise = wk_sync[1] & ~wk_prev;

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  bbc_pkg::bbc_state_e state;
  logic [2:0]  cnt;
  logic [11:0] pc;
  logic [7:0]  op_q;
  logic [7:0]  ab_q;
  logic [7:0]  disp_q;
  logic        bit_q;
  logic [2:0]  sp;
  logic [13:0] stack [0:5];

  wire        in_fetch = (state == bbc_pkg::ST_FETCH);
  wire        in_exec  = (state == bbc_pkg::ST_EXEC);
  // The opcode is decoded straight from memory in its fetch cycle, then from the latch.
  wire [7:0]  dop      = in_fetch ? prog_data : op_q;
  wire        is_short = ~dop[0];
  wire        is_btest = (dop[3:0] == bbc_pkg::LO_BTEST);
  wire        is_bitop = (dop[3:0] == bbc_pkg::LO_BITOP);
  wire        is_call  = (dop[3:0] == bbc_pkg::LO_CALL);
  wire        is_jump  = (dop[3:0] == bbc_pkg::LO_JUMP);
  wire        is_nop   = (dop == bbc_pkg::OP_NOP);
  wire        is_ret   = (dop == bbc_pkg::OP_RET);
  wire        is_interrupt_return  = (dop == bbc_pkg::OP_INTERRUPT_RETURN);
  wire        is_halt  = (dop == bbc_pkg::OP_HALT);
  wire        is_idle  = (dop == bbc_pkg::OP_IDLE);
  wire        is_ctrl  = is_nop | is_ret | is_interrupt_return | is_halt | is_idle;
  wire        is_long  = is_call | is_jump;
  wire        is_multi = is_btest | is_bitop | is_long;
  wire        is_unk   = ~(is_short | is_multi | is_ctrl);
  wire        go_sleep = is_halt | is_idle;

  wire [2:0]  cyc_total = is_short ? bbc_pkg::CYC_SHORT :
                          is_btest ? bbc_pkg::CYC_BTEST :
                          is_bitop ? bbc_pkg::CYC_BITOP :
                          is_long  ? bbc_pkg::CYC_JUMP  :
                                     bbc_pkg::CYC_CTRL;
  wire        last      = in_exec && (cnt == cyc_total - 3'd1);

  // Short branch condition and displacement.
  wire [1:0]  cond_sel  = dop[2:1];
  wire        cond_true = ((cond_sel == bbc_pkg::COND_NZ) & ~flag_z) |
                          ((cond_sel == bbc_pkg::COND_NC) & ~flag_c) |
                          ((cond_sel == bbc_pkg::COND_Z)  &  flag_z) |
                          ((cond_sel == bbc_pkg::COND_C)  &  flag_c);
  wire [11:0] short_ext = {{7{dop[7]}}, dop[7:3]};
  wire [11:0] short_tgt = pc + bbc_pkg::LEN_ONE + short_ext;

  // Bit number sits reversed in the top three opcode bits; bit 4 is the polarity.
  wire [2:0]  bit_num   = {dop[5], dop[6], dop[7]};
  wire        polarity  = dop[4];
  wire        sel_bit;
  wire [7:0]  mod_byte;

  bbc_bitop u_bitop (
    .byte_in  (data_rdata),
    .bit_num  (bit_num),
    .set_val  (polarity),
    .bit_out  (sel_bit),
    .byte_out (mod_byte)
  );

  wire        bt_hit    = (bit_q == polarity);
  wire [11:0] bt_ext    = {{4{disp_q[7]}}, disp_q};
  wire [11:0] bt_tgt    = pc + bbc_pkg::BT_BASE + bt_ext;
  wire [11:0] jump_tgt  = {dop[7:4], ab_q};

  // Return stack; the flags are saved beside the address for the interrupt return.
  wire [2:0]  sp_dec    = (sp == 3'd0) ? bbc_pkg::STACK_DEPTH - 3'd1 : sp - 3'd1;
  wire [2:0]  sp_inc    = (sp == bbc_pkg::STACK_DEPTH - 3'd1) ? 3'd0 : sp + 3'd1;
  wire [13:0] top       = stack[sp_dec];

  wire [11:0] next_pc =
    is_short ? (cond_true ? short_tgt : pc + bbc_pkg::LEN_ONE) :
    is_btest ? (bt_hit ? bt_tgt : pc + bbc_pkg::LEN_THREE) :
    is_bitop ? pc + bbc_pkg::LEN_TWO :
    is_long  ? jump_tgt :
    (is_ret | is_interrupt_return) ? top[11:0] :
                         pc + bbc_pkg::LEN_ONE;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= bbc_pkg::ST_FETCH;
      cnt   <= 3'd0;
    end else begin
      case (state)
        bbc_pkg::ST_FETCH: begin
          state <= bbc_pkg::ST_EXEC;
          cnt   <= 3'd1;
        end
        bbc_pkg::ST_EXEC: begin
          cnt <= cnt + 3'd1;
          if (last) begin
            state <= go_sleep ? bbc_pkg::ST_SLEEP : bbc_pkg::ST_FETCH;
          end
        end
        bbc_pkg::ST_SLEEP: begin
          if (wake_rise) begin
            state <= bbc_pkg::ST_FETCH;
          end
        end
        default: begin
          state <= bbc_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Program counter and program memory port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pc            <= bbc_pkg::PC_RESET;
      prog_req.rd   <= 1'b1;
      prog_req.addr <= bbc_pkg::PC_RESET;
    end else begin
      prog_req.rd <= 1'b0;
      if (in_fetch && is_multi) begin
        prog_req.rd   <= 1'b1;
        prog_req.addr <= pc + bbc_pkg::LEN_ONE;
      end
      if (in_exec && cnt == 3'd2 && is_btest) begin
        prog_req.rd   <= 1'b1;
        prog_req.addr <= pc + bbc_pkg::LEN_TWO;
      end
      if (last) begin
        pc            <= next_pc;
        prog_req.rd   <= ~go_sleep;
        prog_req.addr <= next_pc;
      end
      if (state == bbc_pkg::ST_SLEEP && wake_rise) begin
        prog_req.rd <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operand latches and data space port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_q     <= 8'h00;
      ab_q     <= 8'h00;
      disp_q   <= 8'h00;
      bit_q    <= 1'b0;
      data_req <= '0;
    end else begin
      data_req.rd <= 1'b0;
      data_req.wr <= 1'b0;
      if (in_fetch) begin
        op_q <= prog_data;
      end
      if (in_exec && cnt == 3'd1) begin
        ab_q <= prog_data;
        if (is_btest | is_bitop) begin
          data_req.rd   <= 1'b1;
          data_req.addr <= prog_data;
        end
      end
      if (in_exec && cnt == 3'd2) begin
        bit_q <= sel_bit;
        if (is_bitop) begin
          data_req.wr    <= 1'b1;
          data_req.wdata <= mod_byte;
        end
      end
      if (in_exec && cnt == 3'd3 && is_btest) begin
        disp_q <= prog_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flags and status
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_z      <= 1'b0;
      flag_c      <= 1'b0;
      halted      <= 1'b0;
      idle        <= 1'b0;
      unsupported <= 1'b0;
      instr_addr  <= bbc_pkg::PC_RESET;
    end else begin
      instr_addr  <= pc;
      unsupported <= last & is_unk;
      if (last && is_btest) begin
        flag_c <= bit_q;
      end
      if (last && is_interrupt_return) begin
        flag_z <= top[13];
        flag_c <= top[12];
      end
      if (last && go_sleep) begin
        halted <= is_halt & ~wd_on;
        idle   <= is_idle | (is_halt & wd_on);
      end
      if (state == bbc_pkg::ST_SLEEP && wake_rise) begin
        halted <= 1'b0;
        idle   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (in_exec && cnt == 3'd2 && is_call) begin
      stack[sp] <= {flag_z, flag_c, pc + bbc_pkg::LEN_TWO};
    end
  end

  // A full stack wraps and overwrites the oldest entry rather than stalling.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp <= 3'd0;
    end else if (in_exec && cnt == 3'd2 && is_call) begin
      sp <= sp_inc;
    end else if (last && (is_ret | is_interrupt_return)) begin
      sp <= sp_dec;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  short_timing_a: assert property (in_fetch && is_short |-> ##1 !in_fetch ##1 in_fetch)
    else $error("short branch did not take two cycles");
  short_target_a: assert property (in_fetch && is_short && cond_true |->
    ##2 (pc == $past(pc, 2) + bbc_pkg::LEN_ONE + $past(short_ext, 2)))
    else $error("short branch landed at wrong address");
  not_taken_a: assert property (in_fetch && is_short && !cond_true |->
    ##2 (pc == $past(pc, 2) + bbc_pkg::LEN_ONE))
    else $error("untaken short branch did not fall through");
  short_flags_a: assert property (in_fetch && is_short |->
    ##2 (flag_z == $past(flag_z, 2) && flag_c == $past(flag_c, 2)))
    else $error("short branch changed a flag");
  btest_timing_a: assert property (in_fetch && is_btest |-> ##1 !in_fetch [*4] ##1 in_fetch)
    else $error("bit test branch did not take five cycles");
  btest_carry_a: assert property (in_fetch && is_btest |->
    ##5 (flag_c == $past(sel_bit, 3) && flag_z == $past(flag_z, 5)))
    else $error("tested bit not copied to carry");
  btest_target_a: assert property (in_fetch && is_btest |->
    ##5 (pc == $past(pc, 5) + ((bit_q == op_q[4]) ? bbc_pkg::BT_BASE + bt_ext
                                                 : bbc_pkg::LEN_THREE)))
    else $error("bit test branch landed at wrong address");
  bitop_write_a: assert property (in_fetch && is_bitop |->
    ##3 (data_req.wr && data_req.addr == $past(prog_data, 2)) ##1 in_fetch)
    else $error("bit set or clear write missing or misplaced");
  bit_read_a: assert property (in_fetch && (is_btest || is_bitop) |->
    ##2 (data_req.rd && data_req.addr == $past(prog_data, 1)))
    else $error("data byte read missing or misplaced");
  jump_target_a: assert property (in_fetch && is_long |->
    ##4 (in_fetch && pc == {op_q[7:4], ab_q} && flag_c == $past(flag_c, 4)))
    else $error("jump or call target wrong");
  halt_idle_a: assert property (in_fetch && prog_data == bbc_pkg::OP_HALT && wd_on |->
    ##2 (idle && !halted))
    else $error("halt not replaced by idle under watchdog option");
  ctrl_flags_a: assert property (in_fetch && is_ctrl && !is_interrupt_return |->
    ##2 (flag_z == $past(flag_z, 2) && flag_c == $past(flag_c, 2)))
    else $error("control instruction changed a flag");

  short_taken_c: cover property (in_fetch && is_short && cond_true);
  btest_taken_c: cover property (in_fetch && is_btest ##5 (pc != $past(pc, 5) + bbc_pkg::LEN_THREE));
  bitop_write_c: cover property (data_req.wr);
  halt_idle_c:   cover property (in_fetch && is_halt && wd_on ##2 idle);

endmodule

// *** tb/bbc_mem_model.sv ***
// Program and data memory model facing the branch, bit and control sequencer.
module bbc_mem_model (
  // Clock
  input  wire logic               core_clk,
  // Requests from the core
  input  wire bbc_pkg::bbc_preq_s prog_req,
  input  wire bbc_pkg::bbc_dreq_s data_req,
  // Read data
  output      logic [7:0]         prog_data,
  output      logic [7:0]         data_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] prog [4096];
  logic [7:0] dmem [256];
  logic [7:0] last_p = 8'h00;
  logic [7:0] last_d = 8'h00;

  // Unselected reads show the inverse of the last byte, so a core that samples
  // without a strobe never sees stale data that happens to be right.
  assign prog_data  = prog_req.rd ? prog[prog_req.addr] : ~last_p;
  assign data_rdata = data_req.rd ? dmem[data_req.addr] : ~last_d;

  always @(posedge core_clk) begin
    last_p <= prog_data;
    last_d <= data_rdata;
    if (data_req.wr) begin
      dmem[data_req.addr] <= data_req.wdata;
    end
  end
endmodule

// *** tb/branch_bit_control_decode_bench.sv ***
// Self-checking bench for the branch, bit and control sequencer.
module branch_bit_control_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic               core_clk    = 1'b0;
  logic               rstn        = 1'b0;
  logic               wdog_option = 1'b0;
  logic               wake        = 1'b0;
  bbc_pkg::bbc_preq_s prog_req;
  bbc_pkg::bbc_dreq_s data_req;
  logic [7:0]         prog_data;
  logic [7:0]         data_rdata;
  logic [11:0]        instr_addr;
  logic               flag_z;
  logic               flag_c;
  logic               halted;
  logic               idle;
  logic               unsupported;
  int                 failures    = 0;
  int                 checked     = 0;
  int                 cyc         = 0;
  logic [16:0]        fq [$];
  logic [15:0]        wq [$];
  logic [13:0]        stk [$];
  logic [16:0]        fe;
  logic [15:0]        fw;
  logic [7:0]         dm [256];
  logic [11:0]        pc_a;
  logic               ez          = 1'b0;
  logic               ec          = 1'b0;
  logic [31:0]        rs          = 32'h00006F8E;
  logic [11:0]        ua          = 12'h000;
  int                 unk         = 0;

  always #5 core_clk = ~core_clk;

  bbc_core i_dut (
    .core_clk(core_clk), .rstn(rstn), .prog_req(prog_req), .prog_data(prog_data),
    .data_req(data_req), .data_rdata(data_rdata), .wdog_option(wdog_option),
    .wake(wake), .instr_addr(instr_addr), .flag_z(flag_z), .flag_c(flag_c),
    .halted(halted), .idle(idle), .unsupported(unsupported)
  );

  bbc_mem_model i_mem (
    .core_clk(core_clk), .prog_req(prog_req), .data_req(data_req),
    .prog_data(prog_data), .data_rdata(data_rdata)
  );

  function logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction

  task chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task report_and_stop();
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Program builder: lays down bytes and notes every program read to expect
  // --------------------------------------------------------------------------
  task put(input logic [7:0] b);
    i_mem.prog[pc_a] = b;
    pc_a++;
  endtask

  // Gap is the cycle distance from the previous program read; zero skips it.
  task ex(input logic [2:0] gap, input logic [11:0] a);
    fq.push_back({gap, ez, ec, a});
  endtask

  task jmp(input logic [11:0] t, input logic call);
    logic [11:0] p;
    p = pc_a;
    put({t[11:8], call ? bbc_pkg::LO_CALL : bbc_pkg::LO_JUMP});
    put(t[7:0]);
    ex(3'h1, p + 12'h001);
    if (call) stk.push_back({ez, ec, p + 12'h002});
    ex(3'h3, t);
    pc_a = t;
  endtask

  // Jumping two pages up leaves a clean page below for backward targets.
  task hop();
    jmp({pc_a[11:8] + 4'h2, 8'h00}, 1'b0);
  endtask

  task sbr(input logic [1:0] cnd, input logic [4:0] d);
    logic [11:0] p;
    logic        tk;
    p = pc_a;
    tk = cnd[0] ? (ec == cnd[1]) : (ez == cnd[1]);
    put({d, cnd, 1'b0});
    pc_a = tk ? p + 12'h001 + {{7{d[4]}}, d} : p + 12'h001;
    ex(3'h2, pc_a);
  endtask

  task btst(input logic pol, input logic [2:0] b, input logic [7:0] a, input logic [7:0] d);
    logic [11:0] p;
    p = pc_a;
    put({b[0], b[1], b[2], pol, 4'h3});
    put(a);
    put(d);
    ex(3'h1, p + 12'h001);
    ex(3'h2, p + 12'h002);
    ec = dm[a][b];
    pc_a = (ec == pol) ? p + 12'h002 + {{4{d[7]}}, d} : p + 12'h003;
    ex(3'h2, pc_a);
  endtask

  task bop(input logic s, input logic [2:0] b, input logic [7:0] a);
    logic [11:0] p;
    p = pc_a;
    put({b[0], b[1], b[2], s, 4'hB});
    put(a);
    dm[a][b] = s;
    wq.push_back({a, dm[a]});
    ex(3'h1, p + 12'h001);
    ex(3'h3, pc_a);
  endtask

  task ctl(input logic [7:0] op);
    logic [13:0] e;
    put(op);
    if (op == bbc_pkg::OP_RET || op == bbc_pkg::OP_INTERRUPT_RETURN) begin
      e = stk.pop_back();
      pc_a = e[11:0];
      if (op == bbc_pkg::OP_INTERRUPT_RETURN) {ez, ec} = e[13:12];
    end
    ex((op == bbc_pkg::OP_HALT || op == bbc_pkg::OP_IDLE) ? 3'h0 : 3'h2, pc_a);
  endtask

  task wait_lvl(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while ((halted | idle) !== v && n < 500);
    if (n == 500) begin
      failures++;
      report_and_stop();
    end
  endtask

  task slp(input logic h, input logic i);
    wait_lvl(1'b1);
    chk(16'({halted, idle, prog_req.rd}), 16'({h, i, 1'b0}));
    @(posedge core_clk);
    wake <= 1'b1;
    wdog_option <= 1'b1;
    wait_lvl(1'b0);
    @(posedge core_clk);
    wake <= 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // Monitor: every program read and data write takes the oldest note
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      cyc = 0;
    end else begin
      cyc++;
      if (prog_req.rd === 1'b1 && fq.size() > 0) begin
        fe = fq.pop_front();
        chk(16'(prog_req.addr), 16'(fe[11:0]));
        chk(16'({flag_z, flag_c}), 16'(fe[13:12]));
        if (fe[16:14] != 3'h0) chk(16'(cyc), 16'(fe[16:14]));
        cyc = 0;
      end
      if (data_req.wr === 1'b1 && wq.size() > 0) begin
        fw = wq.pop_front();
        chk({data_req.addr, data_req.wdata}, fw);
      end
      // The pulse stands in the cycle after the foreign opcode, when the
      // delayed address still names that opcode.
      if (unsupported === 1'b1) begin
        unk++;
        chk(16'(instr_addr), 16'(ua));
      end
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      dm[i] = rnd();
      i_mem.dmem[i] = dm[i];
    end
    pc_a = 12'h000;
    ex(3'h0, 12'h000);
    hop();
    for (int i = 0; i < 16; i++) bop(i[3], i[2:0], rnd());
    for (int i = 0; i < 16; i++) btst(i[3], i[2:0], rnd(), 8'h10);
    bop(1'b1, 3'h5, 8'hFF);
    hop();
    btst(1'b1, 3'h5, 8'hFF, 8'h80);
    sbr(bbc_pkg::COND_C, 5'h0F);
    sbr(bbc_pkg::COND_NC, 5'h0F);
    sbr(bbc_pkg::COND_Z, 5'h0F);
    jmp({pc_a[11:8] + 4'h2, 8'h40}, 1'b1);
    ctl(bbc_pkg::OP_NOP);
    bop(1'b0, 3'h0, 8'h00);
    btst(1'b0, 3'h0, 8'h00, 8'h7F);
    ctl(bbc_pkg::OP_INTERRUPT_RETURN);
    hop();
    sbr(bbc_pkg::COND_NZ, 5'h10);
    jmp({pc_a[11:8] + 4'h2, 8'h40}, 1'b1);
    ctl(bbc_pkg::OP_RET);
    ua = pc_a;
    ctl(8'h17);
    ctl(bbc_pkg::OP_HALT);
    ctl(bbc_pkg::OP_NOP);
    ctl(bbc_pkg::OP_NOP);
    ctl(bbc_pkg::OP_HALT);
    ctl(bbc_pkg::OP_NOP);
    ctl(bbc_pkg::OP_NOP);
    ctl(bbc_pkg::OP_IDLE);
    ctl(bbc_pkg::OP_NOP);
    put({5'h1F, bbc_pkg::COND_NZ, 1'b0});
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    slp(1'b1, 1'b0);
    slp(1'b0, 1'b1);
    slp(1'b0, 1'b1);
    for (int i = 0; i < 2000 && fq.size() > 0; i++) @(posedge core_clk);
    chk(16'(fq.size() + wq.size()), 16'h0000);
    chk(16'(unk), 16'h0001);
    report_and_stop();
  end
endmodule
